// file: rtl/slsd_defines.svh
// Constants of the port-1 and indicator soft-strap default loader.
// Assumes a 100 MHz mclk and a synchronous active-low rst_n.
//
// Overview of operation
// R1: Six indicator enable bits load from enable straps; each strap defaults to one.
// R2: Two-bit indicator function field loads from function straps, default binary 00.
// R3: Crossover strap, sampled on the shared indicator pin, sets crossover strap-state bit.
// R4: Strap-based crossover select derives port-1 crossover from auto and manual straps.
// R5: Auto strap low with strap select: manual 0 forces MDI, 1 MDIX; default 0.
// R6: Both crossover straps are ignored unless port 1 runs the internal PHY.
// R7: Negotiation enable loads from its strap; default 1 in mode 111, else 0.
// R8: Negotiation strap also shapes 10BASE-T advertisement and PHY mode; speed and duplex always load 1.
// R9: Heartbeat-test-off bit loads from its strap only in MII PHY mode.
// R10: Straps latch at reset release; EEPROM loader values then replace them.
// R11: Digital reset or reload without EEPROM restores latched values, no resampling.
// R12: Shared pin stays an input until the strap is latched, then drives while indicator enable bit 0 is set.
`ifndef SLSD_DEFINES_SVH
`define SLSD_DEFINES_SVH

`define SLSD_SETTLE_CYCLES      2'h2
`define SLSD_EN_STRAP_DEFAULT   6'h3F
`define SLSD_FUN_STRAP_DEFAULT  2'h0
`define SLSD_MANUAL_DEFAULT     1'h0
`define SLSD_HB_DEFAULT         1'h0
`define SLSD_MODE_INTERNAL      3'h7
`define SLSD_MODE_MII_PHY       3'h1
`define SLSD_PHY_MODE_AN        3'h7
`define SLSD_PHY_MODE_FIXED     3'h3
`define SLSD_XSEL_RESET         1'h1

`define SLSD_ADDR_IND_CFG       8'h00
`define SLSD_ADDR_HARDWARE_CONFIGURATION_REGISTER        8'h04
`define SLSD_ADDR_PHY_BASIC     8'h08
`define SLSD_ADDR_PHY_ADV       8'h0C
`define SLSD_ADDR_PHY_SPECIAL   8'h10
`define SLSD_ADDR_MEDIA_CTRL    8'h14
`define SLSD_ADDR_LOADER        8'h18

`define SLSD_BIT_FUN_LO         8
`define SLSD_BIT_MODE_LO        4
`define SLSD_BIT_STATUS_MODE    8

`endif

// file: rtl/slsd_pkg.sv
// Types of the port-1 and indicator soft-strap default loader.
// Assumes slsd_defines.svh supplies every number.
package slsd_pkg;

  typedef enum logic [1:0] {
    PH_SETTLE,
    PH_LOAD,
    PH_RUN
  } slsd_phase_type;

  typedef struct packed {
    slsd_phase_type phase;
    logic [1:0]     settle_cnt;
    logic           latched_xover;
    logic [2:0]     latched_mode;
    logic [5:0]     eff_en;
    logic [1:0]     eff_fun;
    logic           eff_xover;
    logic           eff_manual;
    logic           eff_an;
    logic           eff_hb;
    logic           load_pend;
    logic [5:0]     ind_en;
    logic [1:0]     ind_fun;
    logic           xover_state;
    logic           an;
    logic           spd;
    logic           dup;
    logic           adv10f;
    logic           adv10h;
    logic [2:0]     phy_mode;
    logic           xsel;
    logic           xauto_reg;
    logic           xmdix_reg;
    logic           hb_bit;
    logic           xo_auto;
    logic           xo_mdix;
    logic           ack;
    logic [31:0]    rdata;
  } slsd_state_type;

endpackage

// file: rtl/slsd_sync.sv
// Two-stage synchroniser for pin-level inputs.
// Assumes the inputs are quasi-static straps or slow levels.
`timescale 1ns/1ps
module slsd_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } slsd_sync_state_type;

  slsd_sync_state_type st;
  slsd_sync_state_type next_st;

  always_comb
  begin
    next_st        = st;
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
    if (!rst_n)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  assign sync_out = st.stage2;
endmodule // slsd_sync

// file: rtl/slsd_strap_loader.sv
// Soft-strap default loader for indicators and port 1, Avalon-MM slave.
// Assumes the EEPROM loader runs on mclk and pulses loader_load.
`timescale 1ns/1ps
`include "slsd_defines.svh"
module slsd_strap_loader (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        port1_crossover_indicator_pin_in,
  output logic             port1_crossover_indicator_pin_out,
  output logic             port1_crossover_indicator_pin_oe,
  input  wire logic        indicator0_drive,
  input  wire logic [2:0]  port1_interface_mode_pin,
  input  wire logic        eeprom_present,
  input  wire logic        loader_load,
  input  wire logic [5:0]  loader_enable_straps,
  input  wire logic [1:0]  loader_function_straps,
  input  wire logic        loader_crossover_strap,
  input  wire logic        loader_manual_strap,
  input  wire logic        loader_negotiation_strap,
  input  wire logic        loader_heartbeat_strap,
  output logic [5:0]       indicator_enable_bits,
  output logic [1:0]       indicator_function_field,
  output logic             port1_auto_crossover,
  output logic             port1_force_mdix,
  output logic [2:0]       port1_interface_mode
);
  import slsd_pkg::*;

  slsd_state_type st;
  slsd_state_type next_st;
  logic [3:0]     pins_sync;
  logic           acc_write;
  logic           restore;
  logic           internal_phy;

  slsd_sync #(
    .WIDTH (4)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({port1_interface_mode_pin, port1_crossover_indicator_pin_in}),
    .sync_out (pins_sync)
  );

  assign acc_write    = avs_write && st.ack;
  // Digital reset and reload share a path: without an EEPROM, both restore
  assign restore      = acc_write && (avs_address == `SLSD_ADDR_LOADER)
                        && avs_byteenable[0] && (avs_writedata[1:0] != 2'h0)
                        && !eeprom_present;
  assign internal_phy = (st.latched_mode == `SLSD_MODE_INTERNAL);

  always_comb
  begin
    next_st           = st;
    next_st.load_pend = 1'h0;
    next_st.ack       = (avs_read || avs_write) && !st.ack;
    // Strap latch sequence; pin settles through the synchroniser first
    case (st.phase)
      PH_SETTLE:
      begin
        if (st.settle_cnt == 2'h0)
        begin
          next_st.latched_xover = pins_sync[0]; // R3
          next_st.latched_mode  = pins_sync[3:1];
          next_st.phase         = PH_LOAD;
        end
        else
        begin
          next_st.settle_cnt = st.settle_cnt - 2'h1;
        end
      end
      PH_LOAD:
      begin
        next_st.eff_en     = `SLSD_EN_STRAP_DEFAULT; // R1
        next_st.eff_fun    = `SLSD_FUN_STRAP_DEFAULT; // R2
        next_st.eff_xover  = st.latched_xover; // R10
        next_st.eff_manual = `SLSD_MANUAL_DEFAULT; // R5
        next_st.eff_an     = internal_phy; // R7
        next_st.eff_hb     = `SLSD_HB_DEFAULT;
        next_st.load_pend  = 1'h1;
        next_st.phase      = PH_RUN;
      end
      PH_RUN:
      begin
        if (restore)
        begin
          // Pins are not sampled again; only the latched copy is reused
          next_st.eff_en     = `SLSD_EN_STRAP_DEFAULT; // R11
          next_st.eff_fun    = `SLSD_FUN_STRAP_DEFAULT;
          next_st.eff_xover  = st.latched_xover; // R11
          next_st.eff_manual = `SLSD_MANUAL_DEFAULT;
          next_st.eff_an     = internal_phy;
          next_st.eff_hb     = `SLSD_HB_DEFAULT;
          next_st.load_pend  = 1'h1;
        end
        else if (loader_load)
        begin
          next_st.eff_en     = loader_enable_straps; // R10
          next_st.eff_fun    = loader_function_straps;
          next_st.eff_xover  = loader_crossover_strap;
          next_st.eff_manual = loader_manual_strap;
          next_st.eff_an     = loader_negotiation_strap;
          next_st.eff_hb     = loader_heartbeat_strap;
          next_st.load_pend  = 1'h1;
        end
      end
      default:
      begin
        next_st.phase = PH_SETTLE;
      end
    endcase

    // Software writes; a default load in the same cycle overrides all but the SLSD_ADDR_PHY_SPECIAL fields
    if (acc_write && avs_byteenable[0])
    begin
      case (avs_address)
        `SLSD_ADDR_IND_CFG:
        begin
          next_st.ind_en = avs_writedata[5:0];
        end
        `SLSD_ADDR_PHY_BASIC:
        begin
          next_st.an  = avs_writedata[0];
          next_st.spd = avs_writedata[1];
          next_st.dup = avs_writedata[2];
        end
        `SLSD_ADDR_PHY_ADV:
        begin
          next_st.adv10f   = avs_writedata[0];
          next_st.adv10h   = avs_writedata[1];
          next_st.phy_mode = avs_writedata[`SLSD_BIT_MODE_LO +: 3];
        end
        `SLSD_ADDR_PHY_SPECIAL:
        begin
          next_st.xsel      = avs_writedata[0];
          next_st.xauto_reg = avs_writedata[1];
          next_st.xmdix_reg = avs_writedata[2];
        end
        `SLSD_ADDR_MEDIA_CTRL:
        begin
          next_st.hb_bit = avs_writedata[0];
        end
        default:
        begin
          next_st.hb_bit = st.hb_bit;
        end
      endcase
    end
    if (acc_write && avs_byteenable[1]
        && avs_address == `SLSD_ADDR_IND_CFG)
    begin
      next_st.ind_fun = avs_writedata[`SLSD_BIT_FUN_LO +: 2];
    end

    if (st.load_pend)
    begin
      next_st.ind_en      = st.eff_en; // R1
      next_st.ind_fun     = st.eff_fun; // R2
      next_st.xover_state = st.eff_xover; // R3
      next_st.an          = st.eff_an; // R7
      // Negotiation on advertises 10BASE-T and selects all-capable mode
      next_st.spd         = 1'h1; // R8
      next_st.dup         = 1'h1;
      next_st.adv10f      = st.eff_an; // R8
      next_st.adv10h      = st.eff_an;
      next_st.phy_mode    = st.eff_an ? `SLSD_PHY_MODE_AN
                                      : `SLSD_PHY_MODE_FIXED; // R8
      next_st.hb_bit      = (st.latched_mode == `SLSD_MODE_MII_PHY)
                            ? st.eff_hb : 1'h0; // R9
    end

    // Crossover resolution, meaningful only for the internal PHY
    if (!internal_phy || st.phase != PH_RUN)
    begin
      next_st.xo_auto = 1'h0; // R6
      next_st.xo_mdix = 1'h0;
    end
    else if (st.xsel)
    begin
      next_st.xo_auto = st.eff_xover; // R4
      next_st.xo_mdix = !st.eff_xover && st.eff_manual; // R5
    end
    else
    begin
      next_st.xo_auto = st.xauto_reg;
      next_st.xo_mdix = !st.xauto_reg && st.xmdix_reg;
    end

    next_st.rdata = 32'h0000_0000;
    if (avs_read && !st.ack)
    begin
      case (avs_address)
        `SLSD_ADDR_IND_CFG:
          next_st.rdata = {22'h0, st.ind_fun, 2'h0, st.ind_en};
        `SLSD_ADDR_HARDWARE_CONFIGURATION_REGISTER:
          next_st.rdata = {21'h0, st.latched_mode, 7'h0, st.xover_state};
        `SLSD_ADDR_PHY_BASIC:
          next_st.rdata = {29'h0, st.dup, st.spd, st.an};
        `SLSD_ADDR_PHY_ADV:
          next_st.rdata = {25'h0, st.phy_mode, 2'h0, st.adv10h, st.adv10f};
        `SLSD_ADDR_PHY_SPECIAL:
          next_st.rdata = {27'h0, st.xo_mdix, st.xo_auto, st.xmdix_reg,
                           st.xauto_reg, st.xsel};
        `SLSD_ADDR_MEDIA_CTRL:
          next_st.rdata = {31'h0, st.hb_bit};
        `SLSD_ADDR_LOADER:
          next_st.rdata = {22'h0, eeprom_present,
                           st.phase == PH_RUN, 8'h0};
        default:
          next_st.rdata = 32'h0000_0000;
      endcase
    end
    else if (st.ack)
    begin
      next_st.rdata = st.rdata;
    end

    if (!rst_n)
    begin
      next_st            = '0;
      next_st.phase      = PH_SETTLE;
      next_st.settle_cnt = `SLSD_SETTLE_CYCLES;
      next_st.eff_en     = `SLSD_EN_STRAP_DEFAULT;
      next_st.ind_en     = `SLSD_EN_STRAP_DEFAULT;
      next_st.xsel       = `SLSD_XSEL_RESET;
    end
  end

  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  assign avs_waitrequest   = (avs_read || avs_write) && !st.ack;
  assign avs_readdata      = st.rdata;
  // Strap pin must not be driven until its level is captured
  assign port1_crossover_indicator_pin_oe  = (st.phase == PH_RUN)
                                             && st.ind_en[0]; // R12
  assign port1_crossover_indicator_pin_out = indicator0_drive;
  assign indicator_enable_bits    = st.ind_en;
  assign indicator_function_field = st.ind_fun;
  assign port1_auto_crossover     = st.xo_auto;
  assign port1_force_mdix         = st.xo_mdix;
  assign port1_interface_mode     = st.latched_mode;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_default_load;
    st.load_pend;
  endsequence

  sequence s_restore_req;
    restore && st.phase == PH_RUN;
  endsequence

  property p_enable_load;
    s_default_load |=> st.ind_en == $past(st.eff_en);
  endproperty
  a_enable_load : assert property (p_enable_load) // R1
    else $error("indicator enables not loaded from straps");

  property p_function_load;
    s_default_load |=> st.ind_fun == $past(st.eff_fun);
  endproperty
  a_function_load : assert property (p_function_load) // R2
    else $error("indicator function not loaded from straps");

  property p_xover_state;
    (st.phase == PH_LOAD) |=> ##1 st.xover_state == st.latched_xover;
  endproperty
  a_xover_state : assert property (p_xover_state) // R3
    else $error("crossover strap state bit wrong after latch");

  property p_manual_force;
    (st.phase == PH_RUN && st.xsel && internal_phy && !st.eff_xover)
      |=> (st.xo_mdix == $past(st.eff_manual)) && !st.xo_auto;
  endproperty
  a_manual_force : assert property (p_manual_force) // R5
    else $error("manual crossover strap not applied");

  property p_ignore_straps;
    !internal_phy |=> !st.xo_auto && !st.xo_mdix;
  endproperty
  a_ignore_straps : assert property (p_ignore_straps) // R6
    else $error("crossover active outside internal PHY mode");

  property p_negotiation_default;
    (st.phase == PH_LOAD) |=> st.eff_an == internal_phy ##1 st.an == st.eff_an;
  endproperty
  a_negotiation_default : assert property (p_negotiation_default) // R7
    else $error("negotiation strap default wrong");

  property p_negotiation_shapes;
    s_default_load ##0 st.eff_an |=> st.adv10f && st.adv10h
      && st.phy_mode == `SLSD_PHY_MODE_AN;
  endproperty
  a_negotiation_shapes : assert property (p_negotiation_shapes) // R8
    else $error("negotiation strap did not shape PHY fields");

  property p_heartbeat_mode;
    s_default_load ##0 (st.latched_mode != `SLSD_MODE_MII_PHY)
      |=> !st.hb_bit;
  endproperty
  a_heartbeat_mode : assert property (p_heartbeat_mode) // R9
    else $error("heartbeat bit set outside MII PHY mode");

  property p_loader_override;
    (st.phase == PH_RUN && loader_load && !restore)
      |=> st.eff_en == $past(loader_enable_straps)
      ##1 st.ind_en == $past(loader_enable_straps, 2);
  endproperty
  a_loader_override : assert property (p_loader_override) // R10
    else $error("loader values did not replace strap values");

  property p_restore;
    s_restore_req |=> st.eff_xover == st.latched_xover && st.load_pend
      && st.eff_en == `SLSD_EN_STRAP_DEFAULT;
  endproperty
  a_restore : assert property (p_restore) // R11
    else $error("latched strap values not restored");

  property p_pin_input;
    (st.phase != PH_RUN) |-> !port1_crossover_indicator_pin_oe;
  endproperty
  a_pin_input : assert property (p_pin_input) // R12
    else $error("shared strap pin driven before latch");
endmodule // slsd_strap_loader

// file: sim/test_slsd_strap_loader.sv
// Self-checking bench for the indicator and port-1 soft-strap loader.
// Assumes slsd_strap_loader ends each Avalon access by dropping waitrequest.
`timescale 1ns/1ps
`include "slsd_defines.svh"
module test_slsd_strap_loader;
  typedef struct {
    logic [2:0]  mode;
    logic        pin;
    logic [7:0]  addr;
    logic [31:0] mask;
    logic [31:0] exp;
  } slsd_row_type;

  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic        pin_in, pin_out, pin_oe, drive, ee, ld, ld_x, ld_man;
  logic        ld_neg, ld_hb, auto_x, mdix;
  logic [2:0]  mode_pin, mode_out;
  logic [5:0]  ld_en, en_bits;
  logic [1:0]  ld_fun, fun_bits;
  int          fails, cmp_count, cycles;

  slsd_row_type rows[13] = '{
    '{3'h7, 1'h1, `SLSD_ADDR_IND_CFG, 32'h33F, 32'h03F},
    '{3'h7, 1'h1, `SLSD_ADDR_HARDWARE_CONFIGURATION_REGISTER, 32'h701, 32'h701},
    '{3'h7, 1'h1, `SLSD_ADDR_PHY_BASIC, 32'h7, 32'h7},
    '{3'h7, 1'h1, `SLSD_ADDR_PHY_ADV, 32'h73, 32'h73},
    '{3'h7, 1'h1, `SLSD_ADDR_PHY_SPECIAL, 32'h09, 32'h09},
    '{3'h7, 1'h1, `SLSD_ADDR_MEDIA_CTRL, 32'h1, 32'h0},
    '{3'h7, 1'h1, `SLSD_ADDR_LOADER, 32'h300, 32'h100},
    '{3'h7, 1'h0, `SLSD_ADDR_HARDWARE_CONFIGURATION_REGISTER, 32'h701, 32'h700},
    '{3'h7, 1'h0, `SLSD_ADDR_PHY_SPECIAL, 32'h19, 32'h01},
    '{3'h1, 1'h1, `SLSD_ADDR_HARDWARE_CONFIGURATION_REGISTER, 32'h701, 32'h101},
    '{3'h1, 1'h1, `SLSD_ADDR_PHY_BASIC, 32'h7, 32'h6},
    '{3'h1, 1'h1, `SLSD_ADDR_PHY_ADV, 32'h73, 32'h30},
    '{3'h1, 1'h1, `SLSD_ADDR_PHY_SPECIAL, 32'h18, 32'h00}
  };

  slsd_strap_loader dut_u (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .port1_crossover_indicator_pin_in(pin_in),
    .port1_crossover_indicator_pin_out(pin_out),
    .port1_crossover_indicator_pin_oe(pin_oe), .indicator0_drive(drive),
    .port1_interface_mode_pin(mode_pin), .eeprom_present(ee),
    .loader_load(ld), .loader_enable_straps(ld_en),
    .loader_function_straps(ld_fun), .loader_crossover_strap(ld_x),
    .loader_manual_strap(ld_man), .loader_negotiation_strap(ld_neg),
    .loader_heartbeat_strap(ld_hb), .indicator_enable_bits(en_bits),
    .indicator_function_field(fun_bits), .port1_auto_crossover(auto_x),
    .port1_force_mdix(mdix), .port1_interface_mode(mode_out)
  );

  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // Indicator level toggles so the shared pin pass-through is exercised
  always @(posedge mclk)
  begin
    drive <= ~drive;
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request holds until waitrequest is seen low, released at that same edge
  task automatic bus(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wdata);
    @(posedge mclk);
    avs_address   <= addr;
    avs_writedata <= wdata;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'h0);
    d = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] mask,
                        input logic [31:0] exp, input string what);
    bus(1'h0, addr, 32'h0);
    check(what, d & mask, exp);
  endtask

  task automatic do_reset(input logic [2:0] mode, input logic pin);
    @(posedge mclk);
    rst_n    <= 1'h0;
    mode_pin <= mode;
    pin_in   <= pin;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    check("oe_in_reset", 32'(pin_oe), 32'h0);
    @(posedge mclk);
    rst_n <= 1'h1;
    @(negedge mclk);
    check("oe_settle", 32'(pin_oe), 32'h0);
    repeat (8) @(posedge mclk);
  endtask

  task automatic load(input logic [5:0] en, input logic [1:0] fun,
                      input logic [3:0] bits);
    @(posedge mclk);
    ld_en <= en;
    ld_fun <= fun;
    {ld_x, ld_man, ld_neg, ld_hb} <= bits;
    ld <= 1'h1;
    @(posedge mclk);
    ld <= 1'h0;
    repeat (4) @(posedge mclk);
  endtask

  initial
  begin
    {rst_n, avs_read, avs_write, ld, ee, ld_x, ld_man, ld_neg} = '0;
    {ld_hb, ld_en, ld_fun, avs_address, avs_writedata} = '0;
    {pin_in, drive, mode_pin, fails, cmp_count, cycles} = '0;
    do_reset(3'h7, 1'h1);
    foreach (rows[i])
    begin
      if (rows[i].mode !== mode_pin || rows[i].pin !== pin_in)
        do_reset(rows[i].mode, rows[i].pin);
      rd_chk(rows[i].addr, rows[i].mask, rows[i].exp,
             $sformatf("row%0d", i));
    end
    // MII PHY mode: crossover straps ignored, heartbeat strap honoured
    load(6'h3F, 2'h0, 4'hD);
    rd_chk(`SLSD_ADDR_MEDIA_CTRL, 32'h1, 32'h1, "hb_mii");
    @(negedge mclk);
    check("xo_mii", {30'h0, auto_x, mdix}, 32'h0);
    check("mode_out", 32'(mode_out), 32'h1);
    do_reset(3'h7, 1'h0);
    @(negedge mclk);
    check("oe_run", 32'(pin_oe), 32'h1);
    check("pin_out", 32'(pin_out), 32'(drive));
    check("xo_strap", {30'h0, auto_x, mdix}, 32'h0);
    // Loader overrides straps; internal PHY ignores the heartbeat value
    @(posedge mclk);
    ee <= 1'h1;
    load(6'h2A, 2'h2, 4'h5);
    rd_chk(`SLSD_ADDR_IND_CFG, 32'h33F, 32'h22A, "ind_load");
    rd_chk(`SLSD_ADDR_MEDIA_CTRL, 32'h1, 32'h0, "hb_int");
    rd_chk(`SLSD_ADDR_PHY_BASIC, 32'h1, 32'h0, "an_load");
    @(negedge mclk);
    check("en_out", 32'(en_bits), 32'h2A);
    check("fun_out", 32'(fun_bits), 32'h2);
    check("xo_man", {30'h0, auto_x, mdix}, 32'h1);
    check("oe_off", 32'(pin_oe), 32'h0);
    // Reload without an EEPROM restores latched values, pin not resampled
    @(posedge mclk);
    ee <= 1'h0;
    pin_in <= 1'h1;
    bus(1'h1, `SLSD_ADDR_LOADER, 32'h1);
    repeat (4) @(posedge mclk);
    rd_chk(`SLSD_ADDR_IND_CFG, 32'h33F, 32'h03F, "ind_reload");
    rd_chk(`SLSD_ADDR_HARDWARE_CONFIGURATION_REGISTER, 32'h701, 32'h700, "hw_reload");
    @(negedge mclk);
    check("xo_reload", {30'h0, auto_x, mdix}, 32'h0);
    bus(1'h1, `SLSD_ADDR_IND_CFG, 32'h0);
    rd_chk(`SLSD_ADDR_IND_CFG, 32'h33F, 32'h0, "ind_wr");
    bus(1'h1, `SLSD_ADDR_LOADER, 32'h2);
    repeat (4) @(posedge mclk);
    rd_chk(`SLSD_ADDR_IND_CFG, 32'h33F, 32'h03F, "ind_digrst");
    // Register path chosen instead of straps
    bus(1'h1, `SLSD_ADDR_PHY_SPECIAL, 32'h4);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check("xo_reg", {30'h0, auto_x, mdix}, 32'h1);
    bus(1'h1, `SLSD_ADDR_PHY_SPECIAL, 32'h6);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check("xo_reg_auto", {30'h0, auto_x, mdix}, 32'h2);
    rd_chk(8'h1C, 32'hFFFFFFFF, 32'h0, "unmapped");
    bus(1'h1, `SLSD_ADDR_HARDWARE_CONFIGURATION_REGISTER, 32'hFFFFFFFF);
    rd_chk(`SLSD_ADDR_HARDWARE_CONFIGURATION_REGISTER, 32'h701, 32'h700, "hw_ro");
    tally_and_finish();
  end
endmodule // test_slsd_strap_loader
